// ### sttt_pkg.sv
// Constants and types shared by the system tick and task timer block
// Operation
// [R01] Five periodic channels with interrupts and triggers
// [R02] Each channel: 32-bit down counter, auto reload
// [R03] Four channels on system clock, one crystal
// [R04] Wake channel runs in stop, requests restart
// [R05] Zero count raises interrupt or trigger optionally
// [R06] No pins; outputs are internal signals only
// [R07] Task counter 32-bit, 8-bit prescaled system clock
// [R08] Four 32-bit compare values against shared counter
// [R09] Each compare raises its own interrupt
// [R10] Task counter optionally halts in debug mode
// [R11] Zero reloads from load value, keeps counting
// [R12] Task counter steps per prescale tick, wraps
package sttt_pkg;

	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int unsigned STTT_CHANNELS   = 5;
	localparam int unsigned STTT_WAKE_CHAN  = 4;
	localparam int unsigned STTT_CNT_WIDTH  = 32;
	localparam int unsigned STTT_PRE_WIDTH  = 8;
	localparam int unsigned STTT_COMPARES   = 4;
	localparam int unsigned STTT_SYNC_DEPTH = 2;

	// ------------------------------------------------------------
	// Values after reset and steps of one
	// ------------------------------------------------------------
	localparam logic [31:0] STTT_COUNT_RESET = 32'h00000000;
	localparam logic [31:0] STTT_COUNT_ONE   = 32'h00000001;
	localparam logic [7:0]  STTT_PRE_RESET   = 8'h00;
	localparam logic [7:0]  STTT_PRE_ONE     = 8'h01;

	// Task counter run state
	typedef enum logic [2:0] {
		STTT_TASK_IDLE   = 3'b001,
		STTT_TASK_RUN    = 3'b010,
		STTT_TASK_FROZEN = 3'b100
	} sttt_task_state_type;

endpackage

// ### sttt_down_channel.sv
// One reloading down-counter channel of the periodic tick timer
module sttt_down_channel
	import sttt_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        enable,
	input  wire logic        tick,
	input  wire logic [31:0] load_value,
	input  wire logic        irq_enable,
	input  wire logic        trig_enable,
	input  wire logic        flag_clear,
	output logic [31:0]      count,
	output logic             irq,
	output logic             trig,
	output logic             expire
);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	logic [31:0] count_reg;
	logic        irq_reg;
	logic        trig_reg;
	logic        expire_reg;
	logic        at_zero;

	assign at_zero = (count_reg == STTT_COUNT_RESET);

	// [R02] Down count, automatic reload
	// A disabled channel holds the load value so enabling starts a full period
	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= STTT_COUNT_RESET;
		end else if (!enable) begin
			count_reg <= load_value;
		end else if (tick) begin
			// [R11] Reload from load value
			if (at_zero) begin
				count_reg <= load_value;
			end else begin
				count_reg <= count_reg - STTT_COUNT_ONE;
			end
		end
	end

	// [R05] Zero raises optional trigger
	always_ff @(posedge clk) begin
		if (rst) begin
			trig_reg   <= 1'b0;
			expire_reg <= 1'b0;
		end else begin
			expire_reg <= enable && tick && at_zero;
			trig_reg   <= enable && tick && at_zero && trig_enable;
		end
	end

	// [R05] Sticky interrupt flag
	// Set beats clear so an expiry in the clearing cycle is kept
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else if (enable && tick && at_zero && irq_enable) begin
			irq_reg <= 1'b1;
		end else if (flag_clear || !irq_enable) begin
			irq_reg <= 1'b0;
		end
	end

	assign count  = count_reg;
	assign irq    = irq_reg;
	assign trig   = trig_reg;
	assign expire = expire_reg;

endmodule

// ### sttt_top.sv
// System tick and task timers: periodic channels and task monitor counter
module sttt_top
	import sttt_pkg::*;
(
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	// Crystal clock, sampled as a plain asynchronous input
	input  wire logic                                  xtal_clk_in,
	input  wire logic                                  stop_mode,
	input  wire logic                                  debug_mode,
	// Periodic tick timer controls
	input  wire logic                                  tick_timer_enable,
	input  wire logic [STTT_CHANNELS-1:0]              chan_enable,
	input  wire logic [STTT_CHANNELS-1:0][31:0]        chan_load,
	input  wire logic [STTT_CHANNELS-1:0]              chan_irq_enable,
	input  wire logic [STTT_CHANNELS-1:0]              chan_trig_enable,
	input  wire logic [STTT_CHANNELS-1:0]              chan_flag_clear,
	output logic      [STTT_CHANNELS-1:0][31:0]        chan_count,
	output logic      [STTT_CHANNELS-1:0]              chan_irq,
	output logic      [STTT_CHANNELS-1:0]              converter_queue_trig,
	output logic                                       wakeup_request,
	// Task monitor timer controls
	input  wire logic                                  task_enable,
	input  wire logic                                  task_freeze_in_debug,
	input  wire logic [7:0]                            task_prescale,
	input  wire logic [STTT_COMPARES-1:0]              cmp_enable,
	input  wire logic [STTT_COMPARES-1:0][31:0]        cmp_value,
	input  wire logic [STTT_COMPARES-1:0]              cmp_flag_clear,
	output logic      [STTT_COMPARES-1:0]              cmp_irq,
	output logic      [31:0]                           task_count,
	output logic      [2:0]                            task_state
);

	// ------------------------------------------------------------
	// Crystal clock synchroniser and edge detect
	// ------------------------------------------------------------
	logic xtal_meta_reg;
	logic xtal_sync_reg;
	logic xtal_prev_reg;
	logic xtal_tick;

	// Two flops before any logic reads the crystal level
	always_ff @(posedge clk) begin
		if (rst) begin
			xtal_meta_reg <= 1'b0;
			xtal_sync_reg <= 1'b0;
		end else begin
			xtal_meta_reg <= xtal_clk_in;
			xtal_sync_reg <= xtal_meta_reg;
		end
	end

	// Edge detect looks only at the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			xtal_prev_reg <= 1'b0;
		end else begin
			xtal_prev_reg <= xtal_sync_reg;
		end
	end

	// Crystal must run below half the system rate to be seen
	assign xtal_tick = xtal_sync_reg && !xtal_prev_reg;

	// ------------------------------------------------------------
	// Periodic tick timer channels
	// ------------------------------------------------------------
	logic [STTT_CHANNELS-1:0] chan_tick;
	logic [STTT_CHANNELS-1:0] chan_run;
	logic [STTT_CHANNELS-1:0] chan_expire;

	// [R03] Clock source per channel
	// [R04] Wake channel ignores stop mode
	// System channels halt in stop, since the system clock is gated then
	always_comb begin
		for (int i = 0; i < STTT_CHANNELS; i++) begin
			if (i == STTT_WAKE_CHAN) begin
				chan_tick[i] = xtal_tick;
			end else begin
				chan_tick[i] = !stop_mode;
			end
			chan_run[i] = tick_timer_enable && chan_enable[i];
		end
	end

	// [R01] Five independent channels
	// [R06] Outputs stay internal signals
	for (genvar g = 0; g < STTT_CHANNELS; g++) begin : g_chan
		sttt_down_channel u_chan (
			.clk         (clk),
			.rst         (rst),
			.enable      (chan_run[g]),
			.tick        (chan_tick[g]),
			.load_value  (chan_load[g]),
			.irq_enable  (chan_irq_enable[g]),
			.trig_enable (chan_trig_enable[g]),
			.flag_clear  (chan_flag_clear[g]),
			.count       (chan_count[g]),
			.irq         (chan_irq[g]),
			.trig        (converter_queue_trig[g]),
			.expire      (chan_expire[g])
		);
	end

	// ------------------------------------------------------------
	// Wake-up request
	// ------------------------------------------------------------
	logic wake_reg;

	// [R04] Request clock restart
	// Held until the system leaves stop; an expiry outside stop does not set it
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_reg <= 1'b0;
		end else if (chan_expire[STTT_WAKE_CHAN] && stop_mode) begin
			wake_reg <= 1'b1;
		end else if (!stop_mode) begin
			wake_reg <= 1'b0;
		end
	end

	assign wakeup_request = wake_reg;

	// ------------------------------------------------------------
	// Task monitor run state
	// ------------------------------------------------------------
	sttt_task_state_type state_reg;
	sttt_task_state_type state_next;
	logic                frozen;

	assign frozen = task_freeze_in_debug && debug_mode;

	// [R10] Debug freeze selection
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			STTT_TASK_IDLE: begin
				if (task_enable) begin
					state_next = frozen ? STTT_TASK_FROZEN : STTT_TASK_RUN;
				end
			end
			STTT_TASK_RUN: begin
				if (!task_enable) begin
					state_next = STTT_TASK_IDLE;
				end else if (frozen) begin
					state_next = STTT_TASK_FROZEN;
				end
			end
			STTT_TASK_FROZEN: begin
				if (!task_enable) begin
					state_next = STTT_TASK_IDLE;
				end else if (!frozen) begin
					state_next = STTT_TASK_RUN;
				end
			end
			default: begin
				state_next = STTT_TASK_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= STTT_TASK_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign task_state = state_reg;

	// ------------------------------------------------------------
	// Task monitor prescaler and counter
	// ------------------------------------------------------------
	logic [7:0]  pre_reg;
	logic [31:0] task_reg;
	logic        pre_done;
	logic        task_step;

	assign pre_done  = (pre_reg >= task_prescale);
	assign task_step = (state_reg == STTT_TASK_RUN) && pre_done;

	// [R07] Eight-bit prescaler, divide by value plus one
	// Compare with >= so a lowered prescale cannot strand the count
	always_ff @(posedge clk) begin
		if (rst) begin
			pre_reg <= STTT_PRE_RESET;
		end else if (state_reg != STTT_TASK_RUN) begin
			pre_reg <= pre_reg;
		end else if (pre_done) begin
			pre_reg <= STTT_PRE_RESET;
		end else begin
			pre_reg <= pre_reg + STTT_PRE_ONE;
		end
	end

	// [R12] Step and wrap
	// The counter is kept across disable; only reset clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			task_reg <= STTT_COUNT_RESET;
		end else if (task_step) begin
			task_reg <= task_reg + STTT_COUNT_ONE;
		end
	end

	assign task_count = task_reg;

	// ------------------------------------------------------------
	// Compare channels
	// ------------------------------------------------------------
	logic [STTT_COMPARES-1:0] cmp_reg;

	// [R08] Four compares on shared counter
	// [R09] Interrupt when counter passes value
	// Fires on the step that carries the count past the value; set beats clear
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_reg <= '0;
		end else begin
			for (int i = 0; i < STTT_COMPARES; i++) begin
				if (cmp_enable[i] && task_step && (task_reg == cmp_value[i])) begin
					cmp_reg[i] <= 1'b1;
				end else if (cmp_flag_clear[i] || !cmp_enable[i]) begin
					cmp_reg[i] <= 1'b0;
				end
			end
		end
	end

	assign cmp_irq = cmp_reg;

endmodule

// ### sttt_properties.sv
// Checker of the system tick and task timers, bound to the top module
module sttt_checker
	import sttt_pkg::*;
(
	input wire logic                             clk,
	input wire logic                             rst,
	input wire logic                             stop_mode,
	input wire logic                             debug_mode,
	input wire logic                             tick_timer_enable,
	input wire logic [STTT_CHANNELS-1:0]         chan_enable,
	input wire logic [STTT_CHANNELS-1:0][31:0]   chan_load,
	input wire logic [STTT_CHANNELS-1:0]         chan_trig_enable,
	input wire logic [STTT_CHANNELS-1:0][31:0]   chan_count,
	input wire logic [STTT_CHANNELS-1:0]         converter_queue_trig,
	input wire logic                             wakeup_request,
	input wire logic                             task_freeze_in_debug,
	input wire logic [STTT_COMPARES-1:0]         cmp_enable,
	input wire logic [STTT_COMPARES-1:0][31:0]   cmp_value,
	input wire logic [STTT_COMPARES-1:0]         cmp_irq,
	input wire logic [31:0]                      task_count
);
	timeunit 1ns;
	timeprecision 100ps;
	logic run0;

	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	// Channel 0 counts only when both enables are up and not stopped
	assign run0 = tick_timer_enable && chan_enable[0] && !stop_mode;

	reload_on_zero_a: assert property (run0 && chan_count[0] == 32'h0 |=> chan_count[0] == $past(chan_load[0]))
		else $error("Channel 0 did not reload");
	count_down_a: assert property (run0 && chan_count[0] != 32'h0 |=> chan_count[0] == $past(chan_count[0]) - 32'h1)
		else $error("Channel 0 did not step down");
	// Trigger must follow its enable both ways, so a disabled trigger is checked too
	trig_on_zero_a: assert property (run0 && chan_count[0] == 32'h0
		|=> converter_queue_trig[0] == $past(chan_trig_enable[0]))
		else $error("Channel 0 trigger does not follow its enable");
	stop_hold_a: assert property (stop_mode && tick_timer_enable && chan_enable[1] |=> $stable(chan_count[1]))
		else $error("System channel moved in stop");
	wake_clear_a: assert property (!stop_mode |=> !wakeup_request)
		else $error("Wake request outside stop");
	task_step_a: assert property (task_count != $past(task_count) |-> task_count == $past(task_count) + 32'h1)
		else $error("Task counter jumped");
	cmp_beyond_a: assert property (cmp_enable[0] && $past(task_count) == cmp_value[0]
		&& task_count == cmp_value[0] + 32'h1 |-> cmp_irq[0])
		else $error("Compare 0 interrupt missing");
	debug_hold_a: assert property ((debug_mode && task_freeze_in_debug) [*2] |=> $stable(task_count))
		else $error("Task counter ran in debug");
endmodule

bind sttt_top sttt_checker sttt_checker_i (.clk(clk), .rst(rst), .stop_mode(stop_mode), .debug_mode(debug_mode),
	.tick_timer_enable(tick_timer_enable), .chan_enable(chan_enable), .chan_load(chan_load),
	.chan_trig_enable(chan_trig_enable), .chan_count(chan_count), .converter_queue_trig(converter_queue_trig),
	.wakeup_request(wakeup_request), .task_freeze_in_debug(task_freeze_in_debug), .cmp_enable(cmp_enable),
	.cmp_value(cmp_value), .cmp_irq(cmp_irq), .task_count(task_count));

// ### sttt_irq_sink.sv
// Model of the interrupt handler and converter queue trigger inputs
module sttt_irq_sink
	import sttt_pkg::*;
(
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire logic                             ack_en,
	input  wire logic [3:0]                       ack_delay,
	input  wire logic [STTT_CHANNELS-1:0]         chan_irq,
	input  wire logic [STTT_COMPARES-1:0]         cmp_irq,
	input  wire logic [STTT_CHANNELS-1:0]         trig,
	output logic      [STTT_CHANNELS-1:0]         chan_flag_clear,
	output logic      [STTT_COMPARES-1:0]         cmp_flag_clear,
	output logic      [STTT_CHANNELS-1:0][15:0]   trig_seen
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] wait_reg;

	// Handler latency; a slow handler lets flags stand longer
	always_ff @(posedge clk) begin
		if (rst || !ack_en || (chan_irq == '0 && cmp_irq == '0))
			wait_reg <= 4'h0;
		else if (wait_reg != ack_delay)
			wait_reg <= wait_reg + 4'h1;
	end

	// Clear every pending flag once the latency has run out
	assign chan_flag_clear = (ack_en && wait_reg == ack_delay) ? chan_irq : '0;
	assign cmp_flag_clear  = (ack_en && wait_reg == ack_delay) ? cmp_irq : '0;

	// Count trigger pulses per queue input
	always_ff @(posedge clk) begin
		if (rst)
			trig_seen <= '0;
		else
			for (int i = 0; i < STTT_CHANNELS; i++)
				trig_seen[i] <= trig_seen[i] + {15'h0, trig[i]};
	end
endmodule

// ### tb_sttt_top.sv
// Self-checking testbench of the system tick and task timers
module tb_sttt_top;
	import sttt_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, xtal_clk_in, stop_mode, debug_mode, tick_timer_enable, task_enable, task_freeze_in_debug;
	logic ack_en, wakeup_request;
	logic [3:0] ack_delay, cmp_enable, cmp_flag_clear, cmp_irq;
	logic [4:0] chan_enable, chan_irq_enable, chan_trig_enable, chan_flag_clear, chan_irq, converter_queue_trig;
	logic [4:0][31:0] chan_load, chan_count;
	logic [3:0][31:0] cmp_value;
	logic [4:0][15:0] trig_seen, snap;
	logic [31:0] task_count, hold;
	logic [7:0] task_prescale;
	logic [2:0] task_state;
	int num_errors, compares, k, hits;

	sttt_top sttt_top_i (.clk, .rst, .xtal_clk_in, .stop_mode, .debug_mode, .tick_timer_enable, .chan_enable,
		.chan_load, .chan_irq_enable, .chan_trig_enable, .chan_flag_clear, .chan_count, .chan_irq,
		.converter_queue_trig, .wakeup_request, .task_enable, .task_freeze_in_debug, .task_prescale,
		.cmp_enable, .cmp_value, .cmp_flag_clear, .cmp_irq, .task_count, .task_state);
	sttt_irq_sink sttt_irq_sink_i (.clk, .rst, .ack_en, .ack_delay, .chan_irq, .cmp_irq,
		.trig(converter_queue_trig), .chan_flag_clear, .cmp_flag_clear, .trig_seen);

	// Clocks: crystal is slow and free running
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		xtal_clk_in = 1'b0;
		forever #100 xtal_clk_in = ~xtal_clk_in;
	end

	task step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task test_done;
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Four system channels with periods 2, 3, 4 and 6 over a common window
	task t_periods;
		chan_load = {32'h3, 32'h5, 32'h3, 32'h2, 32'h1};
		chan_trig_enable = 5'h0E;
		chan_irq_enable = 5'h01;
		chan_enable = 5'h0F;
		tick_timer_enable = 1'b1;
		step(20);
		snap = trig_seen;
		step(120);
		chk({16'h0, trig_seen[0] - snap[0]}, 32'h0);
		for (k = 1; k < 4; k++)
			chk({16'h0, trig_seen[k] - snap[k]}, 32'h78 / (chan_load[k] + 32'h1));
		chk({27'h0, chan_irq}, 32'h1);
		$display("t_periods done");
	endtask

	// Handler clears the flag, so it stands one cycle per period
	task t_ack;
		chan_irq_enable = 5'h02;
		ack_en = 1'b1;
		step(6);
		hits = 0;
		for (k = 0; k < 30; k++) begin
			step(1);
			hits += int'(chan_irq[1]);
		end
		chk(hits, 32'hA);
		$display("t_ack done");
	endtask

	// Stop freezes system channels, crystal channel wakes the system
	task t_stop;
		chan_enable = 5'h1F;
		stop_mode = 1'b1;
		step(1);
		hold = chan_count[1];
		step(10);
		chk(chan_count[1], hold);
		for (k = 0; k < 200 && wakeup_request !== 1'b1; k++)
			step(1);
		chk({31'h0, wakeup_request}, 32'h1);
		stop_mode = 1'b0;
		step(2);
		chk({31'h0, wakeup_request}, 32'h0);
		$display("t_stop done");
	endtask

	// Prescaled counter and compares, one value hit exactly
	task t_task;
		ack_en = 1'b0;
		task_prescale = 8'h03;
		cmp_value = {32'h1E, 32'hF, 32'h7, 32'h3};
		cmp_enable = 4'hF;
		task_enable = 1'b1;
		for (k = 0; k < 100 && task_count !== 32'h5; k++)
			step(1);
		step(40);
		chk(task_count, 32'hF);
		chk({28'h0, cmp_irq}, 32'h3);
		chk({29'h0, task_state}, {29'h0, STTT_TASK_RUN});
		// Handler clears the compare flags before the next step arrives
		ack_en = 1'b1;
		step(2);
		chk({28'h0, cmp_irq}, 32'h0);
		$display("t_task done");
	endtask

	// Debug freeze holds the counter only while selected
	task t_debug;
		debug_mode = 1'b1;
		task_freeze_in_debug = 1'b1;
		step(3);
		hold = task_count;
		step(20);
		chk(task_count, hold);
		chk({29'h0, task_state}, {29'h0, STTT_TASK_FROZEN});
		task_freeze_in_debug = 1'b0;
		step(20);
		chk({31'h0, task_count == hold}, 32'h0);
		chk({29'h0, task_state}, {29'h0, STTT_TASK_RUN});
		$display("t_debug done");
	endtask

	// Main sequence
	initial begin
		{rst, stop_mode, debug_mode, tick_timer_enable, task_enable, task_freeze_in_debug, ack_en} = 7'h40;
		{chan_enable, chan_irq_enable, chan_trig_enable, cmp_enable, ack_delay, task_prescale} = '0;
		chan_load = '0;
		cmp_value = '0;
		step(10);
		rst = 1'b0;
		// Values left by reset, before any stimulus reaches an edge
		chk(task_count, STTT_COUNT_RESET);
		chk({29'h0, task_state}, {29'h0, STTT_TASK_IDLE});
		chk({27'h0, chan_irq}, 32'h0);
		t_periods;
		t_ack;
		t_stop;
		t_task;
		t_debug;
		test_done;
	end

	// Watchdog
	initial begin
		#75000;
		num_errors++;
		test_done;
	end
endmodule
